// ### bench/dmx_deser_tb_top.sv
// self-checking bench for the twelve-lane deserializer
`timescale 1ns/10ps
`define CHK(g, e) chk((g) === (e), 64'(g), 64'(e))
module dmx_deser_tb_top;
  logic clk_sys, resetn, div_preset_n, lane_out_valid, lane_out_ready, word_in_ready;
  logic [11:0] serial_lane_in_pair, lane_out_first, lane_out_second, first_m;
  logic divided_clock_out_a, divided_clock_out_b, cascade_enable_out_a, cascade_enable_out_b;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic reg_wr, reg_rd, hold_off, pq_m, casc_m, ovf_m, armed;
  logic [1:0] div_m;
  logic [5:0] ctrl_m;
  logic [23:0] exp_q[$];
  dmx_pkg::dmx_std_t input_standard;
  int bad_count, samples_checked, hold, cycles;

  dmx_deser DUT (.clk_sys(clk_sys), .resetn(resetn), .serial_lane_in_pair(serial_lane_in_pair),
    .div_preset_n(div_preset_n), .lane_out_first(lane_out_first),
    .lane_out_second(lane_out_second), .lane_out_valid(lane_out_valid),
    .lane_out_ready(lane_out_ready), .word_in_ready(word_in_ready),
    .divided_clock_out_a(divided_clock_out_a), .divided_clock_out_b(divided_clock_out_b),
    .cascade_enable_out_a(cascade_enable_out_a), .cascade_enable_out_b(cascade_enable_out_b),
    .input_standard(input_standard), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  dmx_far_end far (.clk_sys(clk_sys), .hold_off(hold_off),
    .serial_lane_in_pair(serial_lane_in_pair), .lane_out_ready(lane_out_ready));

  initial clk_sys = 1'b0;
  always #50 clk_sys = ~clk_sys;

  task automatic chk(input bit ok, input logic [63:0] g, input logic [63:0] e);
    samples_checked++;
    if (!ok) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
    if (a == dmx_pkg::CTRL_OFS) begin
      ctrl_m = v[5:0];
      hold = 4;
    end
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    v = reg_rdata;
  endtask : rd
  function automatic logic clk_exp(input logic r, q, o, input logic [1:0] dv);
    return r ? dv[1] ^ q : dv[0] ^ o;
  endfunction : clk_exp
  function automatic dmx_pkg::dmx_std_t std_exp(input int i);
    return i == 0 ? dmx_pkg::DMX_STD_LVDS : i == 1 ? dmx_pkg::DMX_STD_ECL : dmx_pkg::DMX_STD_CML;
  endfunction : std_exp
  task automatic summarize;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize

  // ------------------------------------------------------------
  // cycle model of divider, cascade enables and word buffer
  // ------------------------------------------------------------
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 6000) begin
      bad_count++;
      $display("timeout at %0t", $time);
      summarize();
    end
    if (hold > 0) hold--;
    if (!resetn) begin
      pq_m = 0; div_m = 0; casc_m = 0; ovf_m = 0; armed = 1; exp_q.delete();
    end else if (armed) begin
      `CHK(cascade_enable_out_a, casc_m);
      `CHK(cascade_enable_out_b, casc_m);
      if (hold == 0) begin
        `CHK(divided_clock_out_a, clk_exp(ctrl_m[0], ctrl_m[2], ctrl_m[3], div_m));
        `CHK(divided_clock_out_b, clk_exp(ctrl_m[1], ctrl_m[2], ctrl_m[3], div_m));
      end
      `CHK(lane_out_valid, 1'(exp_q.size() != 0));
      `CHK(word_in_ready, 1'(exp_q.size() < 2));
      if (lane_out_valid && lane_out_ready) begin
        `CHK({lane_out_first, lane_out_second}, exp_q[0]);
        void'(exp_q.pop_front());
      end
      if (div_m[0] && pq_m) begin
        if (word_in_ready) exp_q.push_back({first_m, serial_lane_in_pair});
        else ovf_m = 1;
      end
      if (!div_m[0]) first_m = serial_lane_in_pair;
      casc_m = pq_m;
      div_m = pq_m ? div_m + 2'h1 : 2'h0;
      pq_m = div_preset_n;
    end
  end

  initial begin
    resetn = 0; div_preset_n = 0; reg_addr = 0; reg_wdata = 0; reg_wr = 0; reg_rd = 0;
    hold_off = 0; ctrl_m = 0; hold = 0; armed = 0; bad_count = 0; samples_checked = 0;
    cycles = 0; first_m = 0;
    repeat (20) @(posedge clk_sys);
    resetn <= 1;
    rd(dmx_pkg::CTRL_OFS, d); `CHK(d, 32'h0);
    rd(dmx_pkg::STAT_OFS, d); `CHK(d, 32'h0);
    wr(8'h0c, 32'h3f); rd(8'h0c, d); `CHK(d, 32'h0);
    rd(dmx_pkg::CTRL_OFS, d); `CHK(d, 32'h0);
    $display("test registers done");
    @(posedge clk_sys) div_preset_n <= 1;
    repeat (300) @(posedge clk_sys);
    @(posedge clk_sys) div_preset_n <= 0;
    repeat (4) @(posedge clk_sys);
    rd(dmx_pkg::STAT_OFS, d); `CHK(d[6:4], 3'h0);
    @(posedge clk_sys) div_preset_n <= 1;
    $display("test stream and preset done");
    for (int i = 0; i < 16; i++) begin
      wr(dmx_pkg::CTRL_OFS, 32'(i));
      repeat (12) @(posedge clk_sys);
    end
    $display("test clock ratio and phase done");
    for (int i = 0; i < 4; i++) begin
      wr(dmx_pkg::CTRL_OFS, 32'(i) << 4);
      repeat (3) @(posedge clk_sys);
      `CHK(input_standard, std_exp(i));
      rd(dmx_pkg::STAT_OFS, d); `CHK(d[1], 1'(i == 3));
    end
    wr(dmx_pkg::CTRL_OFS, 32'h0);
    $display("test input standard done");
    hold_off <= 1;
    repeat (12) @(posedge clk_sys);
    rd(dmx_pkg::STAT_OFS, d); `CHK(d[3:0], {2'h2, 1'b0, ovf_m});
    `CHK(ovf_m, 1'b1);
    div_preset_n <= 0; hold_off <= 0;
    repeat (10) @(posedge clk_sys);
    wr(dmx_pkg::STAT_OFS, 32'h1); rd(dmx_pkg::STAT_OFS, d); `CHK(d[3:0], 4'h0);
    $display("test overflow done");
    summarize();
  end
endmodule : dmx_deser_tb_top

// ### bench/dmx_far_end.sv
// far-end model: lane data source and stalling word receiver
`timescale 1ns/10ps
module dmx_far_end (
  // clock
  input  wire logic                 clk_sys,
  // stall request from the bench
  input  wire logic                 hold_off,
  // lane source and receiver handshake
  output logic [dmx_pkg::LANES-1:0] serial_lane_in_pair,
  output logic                      lane_out_ready
);
  integer seed = 32'h2331dd25;
  initial begin
    serial_lane_in_pair = 12'h000;
    lane_out_ready = 1'b0;
  end
  // fresh data every edge: a repeated value would hide a missed capture
  always @(posedge clk_sys) begin
    serial_lane_in_pair <= 12'($random(seed));
    lane_out_ready <= !hold_off && (($random(seed) & 3) != 0);
  end
endmodule : dmx_far_end

// ### hw/dmx_deser.sv
// twelve-lane 1-to-2 deserializer with preset divider and word buffer
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps

// Notes on behaviour
// [RQ1] twelve lane splitters, each input lane feeding two output lanes
// [RQ2] lane data captured on both phases of the half-rate clock
// [RQ3] first and second words launched together on half-clock rising edge
// [RQ4] divider makes half and quarter clocks aligned to input clock rise
// [RQ5] low preset forces divider to all-zero state
// [RQ6] preset input resampled on input clock rise before use
// [RQ7] source may assert preset any time; release must meet timing
// [RQ8] each divided clock output selects half (0, default) or quarter (1)
// [RQ9] two divided clock copies, each with its own cascade enable
// [RQ10] all outputs launched from flops on the same edge; the code decodes word outputs and word_in_ready combinationally
// [RQ11] two static selects set output clock phase against data
// [RQ12] phase selects read zero unless driven
// [RQ13] standard select: 00 lvds, 10 ecl, 01 cml, 11 never used; the code decodes control bits [5:4] 01 as ecl, 10 and 11 as cml
// [RQ14] clock and preset inputs use lvds or cml only, never ecl
// [RQ15] divider holds zero while preset low, counts from zero after release
// [RQ16] cascade enables follow the retimed preset
module dmx_deser (
  // clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          resetn,
  // serial lanes and divider preset
  input  wire logic [dmx_pkg::LANES-1:0]     serial_lane_in_pair,
  input  wire logic                          div_preset_n,
  // deserialized word stream
  output logic      [dmx_pkg::LANES-1:0]     lane_out_first,
  output logic      [dmx_pkg::LANES-1:0]     lane_out_second,
  output logic                               lane_out_valid,
  input  wire logic                          lane_out_ready,
  output logic                               word_in_ready,
  // divided clocks, cascade enables and input standard
  output logic                               divided_clock_out_a,
  output logic                               divided_clock_out_b,
  output logic                               cascade_enable_out_a,
  output logic                               cascade_enable_out_b,
  output dmx_pkg::dmx_std_t                  input_standard,
  // register port
  input  wire logic [dmx_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic [dmx_pkg::DATA_W-1:0]    reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [dmx_pkg::DATA_W-1:0]    reg_rdata
);

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  logic                            preset_q_r;
  logic [dmx_pkg::DIV_W-1:0]       div_r;
  logic [dmx_pkg::DIV_W-1:0]       div_nxt;
  logic [dmx_pkg::LANES-1:0]       first_r;
  logic [dmx_pkg::LANES-1:0]       second_nxt;
  logic                            word_done;
  logic [dmx_pkg::CTRL_W-1:0]      ctrl_r;
  logic                            ovf_r;
  logic                            mode_err_r;
  logic [dmx_pkg::WORD_W-1:0]      mem_r [dmx_pkg::FIFO_DEP];
  logic                            wptr_r;
  logic                            rptr_r;
  logic [dmx_pkg::CNT_W-1:0]       cnt_r;
  logic                            fifo_full;
  logic                            fifo_empty;
  logic                            push;
  logic                            pop;
  logic                            half_nxt;
  logic                            quarter_nxt;
  logic [dmx_pkg::WORD_W-1:0]      head;

  // ------------------------------------------------------------
  // preset retiming and divider
  // ------------------------------------------------------------
  // preset is only sampled here; its falling edge may come at any time
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      preset_q_r <= 1'b0;
    end else begin
      preset_q_r <= div_preset_n; // RQ6
    end
  end

  always_comb begin
    if (!preset_q_r) begin
      div_nxt = dmx_pkg::DIV_ZERO; // RQ5 RQ15
    end else begin
      div_nxt = div_r + dmx_pkg::DIV_ONE; // RQ4
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      div_r <= dmx_pkg::DIV_ZERO;
    end else begin
      div_r <= div_nxt; // RQ15
    end
  end

  // ------------------------------------------------------------
  // lane capture
  // ------------------------------------------------------------
  // even phase holds the first bit; odd phase closes the pair
  assign word_done  = preset_q_r && div_r[0]; // RQ2
  assign second_nxt = serial_lane_in_pair;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      first_r <= '0;
    end else if (!div_r[0]) begin
      first_r <= serial_lane_in_pair; // RQ1 RQ2
    end
  end

  // ------------------------------------------------------------
  // two-entry word buffer
  // ------------------------------------------------------------
  // the serial source cannot be stalled, so a full buffer drops the
  // word and flags it rather than corrupting the stored pair
  assign fifo_full     = (cnt_r == dmx_pkg::CNT_W'(dmx_pkg::FIFO_DEP));
  assign fifo_empty    = (cnt_r == '0);
  assign word_in_ready = !fifo_full;
  assign push          = word_done && !fifo_full;
  assign pop           = !fifo_empty && lane_out_ready;
  assign head          = mem_r[rptr_r];

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_r[wptr_r] <= {second_nxt, first_r}; // RQ1 RQ3
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      wptr_r <= 1'b0;
      rptr_r <= 1'b0;
      cnt_r  <= '0;
    end else begin
      if (push) begin
        wptr_r <= !wptr_r;
      end
      if (pop) begin
        rptr_r <= !rptr_r;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 2'h1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 2'h1;
      end
    end
  end

  // first and second leave together from the same stored pair
  assign lane_out_first  = head[dmx_pkg::LANES-1:0]; // RQ3
  assign lane_out_second = head[dmx_pkg::WORD_W-1:dmx_pkg::LANES];
  assign lane_out_valid  = !fifo_empty;

  // ------------------------------------------------------------
  // divided clocks and cascade enables
  // ------------------------------------------------------------
  assign half_nxt    = div_nxt[0] ^ ctrl_r[dmx_pkg::CTRL_OPH]; // RQ11
  assign quarter_nxt = div_nxt[1] ^ ctrl_r[dmx_pkg::CTRL_QPH]; // RQ11

  // registered from the divider's next value so they share its edge
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      divided_clock_out_a <= 1'b0;
      divided_clock_out_b <= 1'b0;
    end else begin
      divided_clock_out_a <= ctrl_r[dmx_pkg::CTRL_RATIO_A] ? quarter_nxt : half_nxt; // RQ8 RQ10
      divided_clock_out_b <= ctrl_r[dmx_pkg::CTRL_RATIO_B] ? quarter_nxt : half_nxt; // RQ8 RQ9
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cascade_enable_out_a <= 1'b0;
      cascade_enable_out_b <= 1'b0;
    end else begin
      cascade_enable_out_a <= preset_q_r; // RQ16 RQ9
      cascade_enable_out_b <= preset_q_r; // RQ16 RQ10
    end
  end

  // ------------------------------------------------------------
  // input standard decode
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      input_standard <= dmx_pkg::DMX_STD_LVDS;
    end else if (ctrl_r[dmx_pkg::CTRL_CML]) begin
      input_standard <= dmx_pkg::DMX_STD_CML; // RQ13
    end else if (ctrl_r[dmx_pkg::CTRL_ECL]) begin
      input_standard <= dmx_pkg::DMX_STD_ECL; // RQ13
    end else begin
      input_standard <= dmx_pkg::DMX_STD_LVDS;
    end
  end

  // ------------------------------------------------------------
  // register port
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ctrl_r <= dmx_pkg::CTRL_RST; // RQ12
    end else if (reg_wr && reg_addr == dmx_pkg::CTRL_OFS) begin
      ctrl_r <= reg_wdata[dmx_pkg::CTRL_W-1:0];
    end
  end

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ovf_r      <= 1'b0;
      mode_err_r <= 1'b0;
    end else begin
      if (word_done && fifo_full) begin
        ovf_r <= 1'b1;
      end else if (reg_wr && reg_addr == dmx_pkg::STAT_OFS && reg_wdata[dmx_pkg::STAT_OVF]) begin
        ovf_r <= 1'b0;
      end
      mode_err_r <= ctrl_r[dmx_pkg::CTRL_ECL] && ctrl_r[dmx_pkg::CTRL_CML]; // RQ13
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      reg_rdata <= '0;
    end else if (reg_rd && reg_addr == dmx_pkg::CTRL_OFS) begin
      reg_rdata <= {{(dmx_pkg::DATA_W-dmx_pkg::CTRL_W){1'b0}}, ctrl_r};
    end else if (reg_rd && reg_addr == dmx_pkg::STAT_OFS) begin
      reg_rdata <= {{(dmx_pkg::DATA_W-dmx_pkg::STAT_W){1'b0}},
                    preset_q_r, div_r, cnt_r, mode_err_r, ovf_r};
    end else begin
      reg_rdata <= '0;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_preset_retime: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ6
    $past(resetn) |-> preset_q_r == $past(div_preset_n))
    else $error("preset not retimed by one edge");

  a_preset_hold: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ5
    !preset_q_r |=> div_r == dmx_pkg::DIV_ZERO)
    else $error("divider not held at zero under preset");

  a_release_count: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ15
    (!preset_q_r ##1 preset_q_r [*3]) |=> div_r == 2'h3)
    else $error("divider did not count from zero after release");

  a_divider_step: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ4
    preset_q_r |=> div_r == $past(div_r) + dmx_pkg::DIV_ONE)
    else $error("divider did not advance");

  a_first_capture: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ2
    !div_r[0] |=> first_r == $past(serial_lane_in_pair))
    else $error("first lane bit not captured");

  a_word_push: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ3
    (word_done && !fifo_full && !lane_out_ready) |=> cnt_r == $past(cnt_r) + 2'h1)
    else $error("completed word not buffered");

  a_word_pair: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ1
    (word_done && fifo_empty) |=> lane_out_valid && lane_out_second == $past(serial_lane_in_pair)
      && lane_out_first == $past(first_r))
    else $error("lane pair not delivered intact");

  a_cascade_follow: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ16
    $past(resetn) |-> cascade_enable_out_a == $past(preset_q_r)
      && cascade_enable_out_b == cascade_enable_out_a)
    else $error("cascade enable does not follow preset");

  a_half_ratio: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ8
    (!ctrl_r[dmx_pkg::CTRL_RATIO_A] && !ctrl_r[dmx_pkg::CTRL_OPH] && preset_q_r)
      [*2] |-> divided_clock_out_a == div_r[0])
    else $error("half-rate clock output wrong");

  a_quarter_ratio: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ8
    (ctrl_r[dmx_pkg::CTRL_RATIO_B] && !ctrl_r[dmx_pkg::CTRL_QPH])
      [*2] |-> divided_clock_out_b == div_r[1])
    else $error("quarter-rate clock output wrong");

  a_phase_default: assert property (@(posedge clk_sys) // RQ12
    $past(!resetn) && resetn |-> ctrl_r == dmx_pkg::CTRL_RST)
    else $error("control selects not zero after reset");

  a_mode_error: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ13
    (ctrl_r[dmx_pkg::CTRL_ECL] && ctrl_r[dmx_pkg::CTRL_CML]) |=> mode_err_r)
    else $error("illegal standard select not flagged");

  a_fifo_bound: assert property (@(posedge clk_sys) disable iff (!resetn)
    cnt_r <= dmx_pkg::CNT_W'(dmx_pkg::FIFO_DEP))
    else $error("buffer count out of range");

  a_head_stands: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ3
    (lane_out_valid && !lane_out_ready) |=> lane_out_valid && $stable(lane_out_first)
      && $stable(lane_out_second))
    else $error("buffer head changed while stalled");

  a_full_drop: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ1
    (word_done && fifo_full) |=> ovf_r)
    else $error("dropped word not flagged");

  a_clock_pair: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ10
    ($past(ctrl_r[dmx_pkg::CTRL_RATIO_A]) == $past(ctrl_r[dmx_pkg::CTRL_RATIO_B]))
      |-> divided_clock_out_a == divided_clock_out_b)
    else $error("divided clocks out of step");

  a_std_lvds: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ13
    (!ctrl_r[dmx_pkg::CTRL_ECL] && !ctrl_r[dmx_pkg::CTRL_CML])
      |=> input_standard == dmx_pkg::DMX_STD_LVDS)
    else $error("lvds standard not selected");

  a_std_ecl: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ13
    (ctrl_r[dmx_pkg::CTRL_ECL] && !ctrl_r[dmx_pkg::CTRL_CML])
      |=> input_standard == dmx_pkg::DMX_STD_ECL)
    else $error("ecl standard not selected");

  a_std_cml: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ13
    (!ctrl_r[dmx_pkg::CTRL_ECL] && ctrl_r[dmx_pkg::CTRL_CML])
      |=> input_standard == dmx_pkg::DMX_STD_CML)
    else $error("cml standard not selected");

  a_quarter_out_a: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ8
    (ctrl_r[dmx_pkg::CTRL_RATIO_A] && !ctrl_r[dmx_pkg::CTRL_QPH])
      [*2] |-> divided_clock_out_a == div_r[1])
    else $error("quarter-rate clock on output a wrong");

  a_half_out_b: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ8
    (!ctrl_r[dmx_pkg::CTRL_RATIO_B] && !ctrl_r[dmx_pkg::CTRL_OPH])
      [*2] |-> divided_clock_out_b == div_r[0])
    else $error("half-rate clock on output b wrong");

  a_out_phase_inv: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ11
    (!ctrl_r[dmx_pkg::CTRL_RATIO_A] && ctrl_r[dmx_pkg::CTRL_OPH])
      [*2] |-> divided_clock_out_a == !div_r[0])
    else $error("half-rate clock phase not inverted");

  a_quarter_phase_inv: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ11
    (ctrl_r[dmx_pkg::CTRL_RATIO_B] && ctrl_r[dmx_pkg::CTRL_QPH])
      [*2] |-> divided_clock_out_b == !div_r[1])
    else $error("quarter-rate clock phase not inverted");

  a_ctrl_write: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ11
    (reg_wr && reg_addr == dmx_pkg::CTRL_OFS)
      |=> ctrl_r == $past(reg_wdata[dmx_pkg::CTRL_W-1:0]))
    else $error("control write not taken");

  a_word_spacing: assert property (@(posedge clk_sys) disable iff (!resetn) // RQ2
    word_done |=> !word_done)
    else $error("words closed on adjacent edges");

endmodule : dmx_deser

// ### hw/dmx_pkg.sv
// constants for the twelve-lane 1-to-2 deserializer
package dmx_pkg;
  // ------------------------------------------------------------
  // structure
  // ------------------------------------------------------------
  localparam int LANES    = 12;
  localparam int WORD_W   = 2 * LANES;
  localparam int DIV_W    = 2;
  localparam int FIFO_DEP = 2;
  localparam int CNT_W    = 2;
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] STAT_OFS = 8'h04;
  localparam logic [5:0]        CTRL_RST = 6'h00;

  // control fields
  localparam int CTRL_RATIO_A  = 0;
  localparam int CTRL_RATIO_B  = 1;
  localparam int CTRL_QPH      = 2;
  localparam int CTRL_OPH      = 3;
  localparam int CTRL_ECL      = 4;
  localparam int CTRL_CML      = 5;
  localparam int CTRL_W        = 6;

  // status fields
  localparam int STAT_OVF      = 0;
  localparam int STAT_MODE_ERR = 1;
  localparam int STAT_CNT_LSB  = 2;
  localparam int STAT_DIV_LSB  = 4;
  localparam int STAT_PRESET   = 6;
  localparam int STAT_W        = 7;

  // divider
  localparam logic [DIV_W-1:0] DIV_ZERO = 2'h0;
  localparam logic [DIV_W-1:0] DIV_ONE  = 2'h1;

  // input standard
  typedef enum logic [1:0] {
    DMX_STD_LVDS,
    DMX_STD_ECL,
    DMX_STD_CML
  } dmx_std_t;
endpackage : dmx_pkg
